// ===== hdl/chan_cfg_pkg.sv
// constants for the channel filter configuration bank
package chan_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 20;
  localparam logic [7:0] A_RESAMP_DEC = 8'h90;
  localparam logic [7:0] A_RESAMP_INT = 8'h91;
  localparam logic [7:0] A_RESAMP_SCALE = 8'h92;
  localparam logic [7:0] A_RSVD_A = 8'h93;
  localparam logic [7:0] A_COMB5_DEC = 8'h94;
  localparam logic [7:0] A_COMB5_SCALE = 8'h95;
  localparam logic [7:0] A_RSVD_B = 8'h96;
  localparam logic [7:0] A_CF_DEC = 8'hA0;
  localparam logic [7:0] A_CF_PHASE = 8'hA1;
  localparam logic [7:0] A_CF_TAPS = 8'hA2;
  localparam logic [7:0] A_CF_OFFSET = 8'hA3;
  localparam logic [7:0] A_CF_CTRL = 8'hA4;
  localparam logic [7:0] A_ST_I = 8'hA5;
  localparam logic [7:0] A_ST_Q = 8'hA6;
  localparam logic [7:0] A_ST_COUNT = 8'hA7;
  localparam logic [7:0] A_OUT_CTRL = 8'hA9;
  localparam int SCALE_INV_BIT = 11;
  localparam int SCALE_WEIGHT_BIT = 10;
  localparam int QUIET_HI = 9;
  localparam int QUIET_LO = 5;
  localparam int LOUD_HI = 4;
  localparam int LOUD_LO = 0;
  localparam int CTRL_BYPASS_BIT = 10;
  localparam int CTRL_INSEL_BIT = 9;
  localparam int CTRL_BANK_BIT = 8;
  localparam int CTRL_COMMON_EXP_BIT = 7;
  localparam int CTRL_FORCE_SCALE_BIT = 6;
  localparam int CTRL_FMT_HI = 5;
  localparam int CTRL_FMT_LO = 4;
  localparam int CTRL_OSCALE_HI = 3;
  localparam int OUT_MAP_BIT = 9;
  localparam int OUT_WIDE_BIT = 5;
  localparam logic [19:0] CNT_RESET = 20'h00000;
  localparam logic [15:0] SIG_RESET = 16'h0000;
  localparam logic [11:0] CFG_RESET = 12'h000;
  localparam logic [15:0] SIG_POLY = 16'hA001;
endpackage

// ===== hdl/channel_filter_config_bank.sv
// per-channel filter configuration bank with self-test signature readout
// How it works
// RL1 - resampling decimation factor is register value plus one, up to 4096
// RL2 - host keeps resampling decimation above interpolation
// RL3 - resampling interpolation factor is register value plus one, up to 512
// RL4 - scale bit 11 inverts input exponent polarity
// RL5 - scale bit 10 picks 6.02 or 12.02 dB per exponent step
// RL6 - scale holds two five-bit values chosen by the level indicator
// RL7 - quiet value while indicator inactive, loud value while active
// RL8 - host writes zero to reserved registers
// RL9 - fifth-order comb decimates by value plus one; host keeps it 1 to 32
// RL10 - coefficient filter decimates by value plus one up to 256
// RL11 - phase reloaded at each filter start, kept across synchronization
// RL12 - tap count is register value plus one
// RL13 - coefficient offset shadowed, takes effect at next filter start
// RL14 - control bit 10 bypasses filter, routes comb output to self-test
// RL15 - control bit 9 selects own or another channel's comb output
// RL16 - control bit 8 selects coefficient memory half for writes
// RL17 - bit 7 selects separate or common floating exponent
// RL18 - bit 6 forces output scale in floating formats, with saturation
// RL19 - bits 5 and 4 select 12+4, 8+4 or fixed point format
// RL20 - bits 3 to 0 are the output scale, used in fixed or forced mode
// RL21 - map bit set presents 16 bits of output data to self-test reads
// RL22 - writing count starts self-test; signatures accumulate that many outputs
// RL23 - count field is bits 19 to 0 and reads back the live counter
// RL24 - map clear gives signatures, map set gives output data
`timescale 1ns/1ps
module channel_filter_config_bank #(
  parameter int CHANNEL = 0
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [chan_cfg_pkg::ADDR_W-1:0] addr_in,
  input wire logic [chan_cfg_pkg::DATA_W-1:0] wdata_in,
  input wire logic level_ind_in,
  input wire logic filter_start_in,
  input wire logic out_valid_in,
  input wire logic [15:0] fmt_i_in,
  input wire logic [15:0] fmt_q_in,
  input wire logic [15:0] comb_i_in,
  input wire logic [15:0] comb_q_in,
  output logic [chan_cfg_pkg::DATA_W-1:0] rdata_out,
  output logic [12:0] resamp_decimation_factor_out,
  output logic [9:0] resamp_interpolation_factor_out,
  output logic exp_invert_out,
  output logic exp_weight_12db_out,
  output logic [4:0] resamp_scale_out,
  output logic [8:0] comb5_decimation_factor_out,
  output logic [4:0] comb5_scale_out,
  output logic [8:0] coef_filter_decimation_factor_out,
  output logic [7:0] coef_filter_phase_value_out,
  output logic [8:0] tap_count_out,
  output logic [7:0] coefficient_offset_pointer_out,
  output logic bypass_to_selftest_out,
  output logic [1:0] input_source_channel_out,
  output logic use_other_input_out,
  output logic coef_bank_high_out,
  output logic common_exponent_out,
  output logic force_scale_out,
  output logic [1:0] output_format_out,
  output logic apply_scale_out,
  output logic [3:0] output_scale_out,
  output logic wide_output_out,
  output logic selftest_busy_out
);
  import chan_cfg_pkg::*;

  initial begin
    if (CHANNEL < 0 || CHANNEL > 3) $error("CHANNEL must be 0 to 3");
  end

  // register storage
  logic [11:0] resamp_dec_reg;
  logic [8:0] resamp_int_reg;
  logic [11:0] resamp_scale_reg;
  logic [7:0] rsvd_a_reg;
  logic [7:0] comb5_dec_reg;
  logic [4:0] comb5_scale_reg;
  logic [7:0] rsvd_b_reg;
  logic [7:0] cf_dec_reg;
  logic [7:0] cf_phase_reg;
  logic [7:0] cf_taps_reg;
  logic [7:0] cf_offset_reg;
  logic [10:0] cf_ctrl_reg;
  logic [9:0] out_ctrl_reg;
  logic [7:0] offset_shadow_reg;
  logic [7:0] phase_live_reg;
  logic [19:0] rdata_reg;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = a == target;
  endfunction

  wire logic we_dec = wr_in && hit(addr_in, A_RESAMP_DEC);
  wire logic we_int = wr_in && hit(addr_in, A_RESAMP_INT);
  wire logic we_scale = wr_in && hit(addr_in, A_RESAMP_SCALE);
  wire logic we_ra = wr_in && hit(addr_in, A_RSVD_A);
  wire logic we_c5d = wr_in && hit(addr_in, A_COMB5_DEC);
  wire logic we_c5s = wr_in && hit(addr_in, A_COMB5_SCALE);
  wire logic we_rb = wr_in && hit(addr_in, A_RSVD_B);
  wire logic we_cfd = wr_in && hit(addr_in, A_CF_DEC);
  wire logic we_cfp = wr_in && hit(addr_in, A_CF_PHASE);
  wire logic we_cft = wr_in && hit(addr_in, A_CF_TAPS);
  wire logic we_cfo = wr_in && hit(addr_in, A_CF_OFFSET);
  wire logic we_ctl = wr_in && hit(addr_in, A_CF_CTRL);
  wire logic we_cnt = wr_in && hit(addr_in, A_ST_COUNT);
  wire logic we_oc = wr_in && hit(addr_in, A_OUT_CTRL);

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      resamp_dec_reg <= CFG_RESET;
      resamp_int_reg <= CFG_RESET[8:0];
      resamp_scale_reg <= CFG_RESET;
      rsvd_a_reg <= CFG_RESET[7:0];
      comb5_dec_reg <= CFG_RESET[7:0];
      comb5_scale_reg <= CFG_RESET[4:0];
      rsvd_b_reg <= CFG_RESET[7:0];
    end else begin
      if (we_dec) resamp_dec_reg <= wdata_in[11:0];
      if (we_int) resamp_int_reg <= wdata_in[8:0];
      if (we_scale) resamp_scale_reg <= wdata_in[11:0];
      // reserved: host writes zero here, value is held only for readback
      if (we_ra) rsvd_a_reg <= wdata_in[7:0];
      if (we_c5d) comb5_dec_reg <= wdata_in[7:0];
      if (we_c5s) comb5_scale_reg <= wdata_in[4:0];
      if (we_rb) rsvd_b_reg <= wdata_in[7:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cf_dec_reg <= CFG_RESET[7:0];
      cf_phase_reg <= CFG_RESET[7:0];
      cf_taps_reg <= CFG_RESET[7:0];
      cf_offset_reg <= CFG_RESET[7:0];
      cf_ctrl_reg <= CFG_RESET[10:0];
      out_ctrl_reg <= CFG_RESET[9:0];
    end else begin
      if (we_cfd) cf_dec_reg <= wdata_in[7:0];
      if (we_cfp) cf_phase_reg <= wdata_in[7:0];
      if (we_cft) cf_taps_reg <= wdata_in[7:0];
      if (we_cfo) cf_offset_reg <= wdata_in[7:0];
      if (we_ctl) cf_ctrl_reg <= wdata_in[10:0];
      if (we_oc) out_ctrl_reg <= wdata_in[9:0];
    end
  end

  // RL13 shadow offset load
  // RL11 phase reload at start
  // writes mid-computation only touch the host copy, never the live pointer
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      offset_shadow_reg <= CFG_RESET[7:0];
      phase_live_reg <= CFG_RESET[7:0];
    end else if (filter_start_in) begin
      offset_shadow_reg <= cf_offset_reg;
      phase_live_reg <= cf_phase_reg;
    end
  end

  // self-test engine
  wire logic map_data = out_ctrl_reg[OUT_MAP_BIT];
  wire logic bypass = cf_ctrl_reg[CTRL_BYPASS_BIT];
  wire logic st_running;
  wire logic [19:0] st_count;
  wire logic [15:0] sig_i;
  wire logic [15:0] sig_q;
  // RL14 comb output feeds self-test
  wire logic [15:0] obs_i = bypass ? comb_i_in : fmt_i_in;
  wire logic [15:0] obs_q = bypass ? comb_q_in : fmt_q_in;
  // RL22 accumulate only while counting
  wire logic st_step = out_valid_in && st_running && !map_data;

  // RL23 live counter
  out_count #(.W(20)) u_count (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .load_in(we_cnt),
    .value_in(wdata_in[19:0]),
    .step_in(st_step),
    .running_out(st_running),
    .count_out(st_count)
  );

  // RL22 signatures cleared at start
  sig_accum #(.W(16)) u_sig_i (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .clear_in(we_cnt),
    .step_in(st_step),
    .data_in(obs_i),
    .sig_out(sig_i)
  );

  sig_accum #(.W(16)) u_sig_q (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .clear_in(we_cnt),
    .step_in(st_step),
    .data_in(obs_q),
    .sig_out(sig_q)
  );

  // captured output data for mapped reads
  logic [15:0] cap_i_reg;
  logic [15:0] cap_q_reg;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cap_i_reg <= SIG_RESET;
      cap_q_reg <= SIG_RESET;
    end else if (out_valid_in) begin
      cap_i_reg <= obs_i;
      cap_q_reg <= obs_q;
    end
  end

  // RL24 signature or data view
  // RL21 mapped output readback
  wire logic [15:0] view_i = map_data ? cap_i_reg : sig_i;
  wire logic [15:0] view_q = map_data ? cap_q_reg : sig_q;

  // read mux; unmapped addresses read zero
  logic [19:0] rmux;
  always_comb begin
    rmux = '0;
    unique case (addr_in)
      A_RESAMP_DEC: rmux = {8'h00, resamp_dec_reg};
      A_RESAMP_INT: rmux = {11'h000, resamp_int_reg};
      A_RESAMP_SCALE: rmux = {8'h00, resamp_scale_reg};
      A_RSVD_A: rmux = {12'h000, rsvd_a_reg};
      A_COMB5_DEC: rmux = {12'h000, comb5_dec_reg};
      A_COMB5_SCALE: rmux = {15'h0000, comb5_scale_reg};
      A_RSVD_B: rmux = {12'h000, rsvd_b_reg};
      A_CF_DEC: rmux = {12'h000, cf_dec_reg};
      A_CF_PHASE: rmux = {12'h000, cf_phase_reg};
      A_CF_TAPS: rmux = {12'h000, cf_taps_reg};
      A_CF_OFFSET: rmux = {12'h000, cf_offset_reg};
      A_CF_CTRL: rmux = {9'h000, cf_ctrl_reg};
      A_ST_I: rmux = {4'h0, view_i};
      A_ST_Q: rmux = {4'h0, view_q};
      A_ST_COUNT: rmux = st_count;
      A_OUT_CTRL: rmux = {10'h000, out_ctrl_reg};
      default: rmux = '0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) rdata_reg <= CNT_RESET;
    else if (rd_in) rdata_reg <= rmux;
  end

  // derived controls
  // RL1 resampling decimation plus one
  wire logic [12:0] rdec_n = {1'b0, resamp_dec_reg} + 13'h0001;
  // RL3 interpolation plus one
  wire logic [9:0] rint_n = {1'b0, resamp_int_reg} + 10'h001;
  // RL7 quiet or loud scale
  // RL6 level indicator choice
  wire logic [4:0] scale_n = level_ind_in ? resamp_scale_reg[LOUD_HI:LOUD_LO]
                                          : resamp_scale_reg[QUIET_HI:QUIET_LO];
  // RL9 comb decimation plus one
  wire logic [8:0] c5_n = {1'b0, comb5_dec_reg} + 9'h001;
  // RL10 filter decimation plus one
  wire logic [8:0] cfd_n = {1'b0, cf_dec_reg} + 9'h001;
  // RL12 taps plus one
  wire logic [8:0] taps_n = {1'b0, cf_taps_reg} + 9'h001;
  // RL15 other channel source map
  wire logic [1:0] other_ch = (CHANNEL == 0) ? 2'h1 : ((CHANNEL == 1) ? 2'h0 : 2'h1);
  wire logic [1:0] src_n = cf_ctrl_reg[CTRL_INSEL_BIT] ? other_ch : 2'(CHANNEL);
  // RL19 format field
  wire logic [1:0] fmt_n = cf_ctrl_reg[CTRL_FMT_HI:CTRL_FMT_LO];
  // RL20 scale in fixed or forced
  // RL18 forced scale saturates downstream
  wire logic apply_n = (fmt_n == 2'h0) || cf_ctrl_reg[CTRL_FORCE_SCALE_BIT];

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      resamp_decimation_factor_out <= 13'h0001;
      resamp_interpolation_factor_out <= 10'h001;
      resamp_scale_out <= 5'h00;
      comb5_decimation_factor_out <= 9'h001;
      coef_filter_decimation_factor_out <= 9'h001;
      tap_count_out <= 9'h001;
      input_source_channel_out <= 2'(CHANNEL);
      apply_scale_out <= 1'b1;
      selftest_busy_out <= 1'b0;
    end else begin
      resamp_decimation_factor_out <= rdec_n;
      resamp_interpolation_factor_out <= rint_n;
      resamp_scale_out <= scale_n;
      comb5_decimation_factor_out <= c5_n;
      coef_filter_decimation_factor_out <= cfd_n;
      tap_count_out <= taps_n;
      input_source_channel_out <= src_n;
      apply_scale_out <= apply_n;
      selftest_busy_out <= st_running;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      exp_invert_out <= 1'b0;
      exp_weight_12db_out <= 1'b0;
      comb5_scale_out <= 5'h00;
      coef_filter_phase_value_out <= 8'h00;
      coefficient_offset_pointer_out <= 8'h00;
      bypass_to_selftest_out <= 1'b0;
      use_other_input_out <= 1'b0;
      coef_bank_high_out <= 1'b0;
      common_exponent_out <= 1'b0;
      force_scale_out <= 1'b0;
      output_format_out <= 2'h0;
      output_scale_out <= 4'h0;
      wide_output_out <= 1'b0;
    end else begin
      // RL4 exponent invert
      exp_invert_out <= resamp_scale_reg[SCALE_INV_BIT];
      // RL5 exponent weight
      exp_weight_12db_out <= resamp_scale_reg[SCALE_WEIGHT_BIT];
      comb5_scale_out <= comb5_scale_reg;
      // RL11 live phase
      coef_filter_phase_value_out <= phase_live_reg;
      // RL13 shadowed pointer
      coefficient_offset_pointer_out <= offset_shadow_reg;
      // RL14 bypass flag
      bypass_to_selftest_out <= bypass;
      use_other_input_out <= cf_ctrl_reg[CTRL_INSEL_BIT];
      // RL16 memory half for writes
      coef_bank_high_out <= cf_ctrl_reg[CTRL_BANK_BIT];
      // RL17 common exponent
      common_exponent_out <= cf_ctrl_reg[CTRL_COMMON_EXP_BIT];
      // RL18 force scale
      force_scale_out <= cf_ctrl_reg[CTRL_FORCE_SCALE_BIT];
      output_format_out <= fmt_n;
      // RL20 output scale field
      output_scale_out <= cf_ctrl_reg[CTRL_OSCALE_HI:0];
      wide_output_out <= out_ctrl_reg[OUT_WIDE_BIT];
    end
  end

  assign rdata_out = rdata_reg;
endmodule

// ===== hdl/out_count.sv
// self-test output down counter
`timescale 1ns/1ps
module out_count #(
  parameter int W = 20
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic load_in,
  input wire logic [W-1:0] value_in,
  input wire logic step_in,
  output logic running_out,
  output logic [W-1:0] count_out
);
  import chan_cfg_pkg::*;
  initial begin
    if (W != 20) $error("out_count width must be 20");
  end
  logic [W-1:0] cnt_reg;
  wire logic run = cnt_reg != '0;
  wire logic [W-1:0] cnt_next = load_in ? value_in : ((step_in && run) ? cnt_reg - W'(1) : cnt_reg);
  always_ff @(posedge clk_in) begin
    if (!nrst_in) cnt_reg <= CNT_RESET;
    else cnt_reg <= cnt_next;
  end
  assign running_out = run;
  assign count_out = cnt_reg;
endmodule

// ===== hdl/sig_accum.sv
// signature accumulator for one output path
`timescale 1ns/1ps
module sig_accum #(
  parameter int W = 16
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic clear_in,
  input wire logic step_in,
  input wire logic [W-1:0] data_in,
  output logic [W-1:0] sig_out
);
  import chan_cfg_pkg::*;
  initial begin
    if (W != 16) $error("sig_accum width must be 16");
  end
  logic [W-1:0] sig_reg;
  // shift-xor keeps every input bit in the signature
  wire logic [W-1:0] shifted = {1'b0, sig_reg[W-1:1]} ^ (sig_reg[0] ? SIG_POLY : '0);
  wire logic [W-1:0] sig_next = clear_in ? SIG_RESET : (step_in ? (shifted ^ data_in) : sig_reg);
  always_ff @(posedge clk_in) begin
    if (!nrst_in) sig_reg <= SIG_RESET;
    else sig_reg <= sig_next;
  end
  assign sig_out = sig_reg;
endmodule

// ===== verif/channel_filter_config_bank_chk.sv
// assertion checker for the channel filter configuration bank
`timescale 1ns/1ps
module channel_filter_config_bank_chk #(
  parameter int CHANNEL = 0
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic wr_in,
  input wire logic [chan_cfg_pkg::ADDR_W-1:0] addr_in,
  input wire logic [chan_cfg_pkg::DATA_W-1:0] wdata_in,
  input wire logic level_ind_in,
  input wire logic filter_start_in,
  input wire logic [12:0] resamp_decimation_factor_out,
  input wire logic [9:0] resamp_interpolation_factor_out,
  input wire logic exp_invert_out,
  input wire logic exp_weight_12db_out,
  input wire logic [4:0] resamp_scale_out,
  input wire logic [8:0] comb5_decimation_factor_out,
  input wire logic [8:0] coef_filter_decimation_factor_out,
  input wire logic [7:0] coef_filter_phase_value_out,
  input wire logic [8:0] tap_count_out,
  input wire logic [7:0] coefficient_offset_pointer_out,
  input wire logic bypass_to_selftest_out,
  input wire logic [1:0] input_source_channel_out,
  input wire logic use_other_input_out,
  input wire logic coef_bank_high_out,
  input wire logic common_exponent_out,
  input wire logic force_scale_out,
  input wire logic [1:0] output_format_out,
  input wire logic apply_scale_out,
  input wire logic [3:0] output_scale_out,
  input wire logic selftest_busy_out
);
  import chan_cfg_pkg::*;
  // partner channel when the other-input bit is set
  localparam logic [1:0] OTHER = (CHANNEL == 1) ? 2'h0 : 2'h1;
  wire logic w_rdec = wr_in && addr_in == A_RESAMP_DEC;
  wire logic w_rint = wr_in && addr_in == A_RESAMP_INT;
  wire logic w_scl = wr_in && addr_in == A_RESAMP_SCALE;
  wire logic w_c5 = wr_in && addr_in == A_COMB5_DEC;
  wire logic w_cdec = wr_in && addr_in == A_CF_DEC;
  wire logic w_taps = wr_in && addr_in == A_CF_TAPS;
  wire logic w_ctrl = wr_in && addr_in == A_CF_CTRL;
  wire logic w_cnt = wr_in && addr_in == A_ST_COUNT;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  AST_RDEC: assert property (w_rdec |-> ##2
    resamp_decimation_factor_out == {1'b0, $past(wdata_in[11:0], 2)} + 13'h0001)
    else $error("resampling decimation factor wrong");
  AST_RINT: assert property (w_rint |-> ##2
    resamp_interpolation_factor_out == {1'b0, $past(wdata_in[8:0], 2)} + 10'h001)
    else $error("resampling interpolation factor wrong");
  AST_EXP: assert property (w_scl |-> ##2
    {exp_invert_out, exp_weight_12db_out} == $past(wdata_in[11:10], 2))
    else $error("exponent control bits wrong");
  AST_SCALE: assert property (w_scl ##1 !wr_in |-> ##1 resamp_scale_out ==
    ($past(level_ind_in) ? $past(wdata_in[4:0], 2) : $past(wdata_in[9:5], 2)))
    else $error("resampling scale selection wrong");
  AST_C5DEC: assert property (w_c5 |-> ##2
    comb5_decimation_factor_out == {1'b0, $past(wdata_in[7:0], 2)} + 9'h001)
    else $error("comb decimation factor wrong");
  AST_CFDEC: assert property (w_cdec |-> ##2
    coef_filter_decimation_factor_out == {1'b0, $past(wdata_in[7:0], 2)} + 9'h001)
    else $error("filter decimation factor wrong");
  AST_TAPS: assert property (w_taps |-> ##2
    tap_count_out == {1'b0, $past(wdata_in[7:0], 2)} + 9'h001)
    else $error("tap count wrong");
  AST_PHASE: assert property ($changed(coef_filter_phase_value_out) |->
    $past(filter_start_in) || $past(filter_start_in, 2))
    else $error("phase changed without filter start");
  AST_OFFSET: assert property ($changed(coefficient_offset_pointer_out) |->
    $past(filter_start_in) || $past(filter_start_in, 2))
    else $error("offset changed without filter start");
  AST_CTRL: assert property (w_ctrl |-> ##2 {bypass_to_selftest_out,
    use_other_input_out, coef_bank_high_out, common_exponent_out, force_scale_out,
    output_format_out, output_scale_out} == $past(wdata_in[10:0], 2))
    else $error("control fields wrong");
  AST_SRC: assert property (input_source_channel_out ==
    (use_other_input_out ? OTHER : 2'(CHANNEL)))
    else $error("input source channel wrong");
  AST_APPLY: assert property (apply_scale_out ==
    (output_format_out == 2'h0 || force_scale_out))
    else $error("apply scale wrong");
  AST_BUSY: assert property (w_cnt && wdata_in > 20'h00001 |-> ##[2:3]
    selftest_busy_out)
    else $error("self test did not start");
  AST_START: assert property ($rose(selftest_busy_out) |->
    $past(w_cnt) || $past(w_cnt, 2) || $past(w_cnt, 3))
    else $error("self test started without count write");
endmodule

bind channel_filter_config_bank channel_filter_config_bank_chk #(.CHANNEL(CHANNEL)) u_chk (.*);

// ===== verif/test_channel_filter_config_bank.sv
// self-checking bench for the channel filter configuration bank
`timescale 1ns/1ps
module test_channel_filter_config_bank;
  import chan_cfg_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic level_ind_in = 1'b0;
  logic filter_start_in = 1'b0;
  logic out_valid_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [19:0] wdata_in = 20'h00000;
  logic [15:0] fmt_i_in = 16'h0000, fmt_q_in = 16'h0000;
  logic [15:0] comb_i_in = 16'h0000, comb_q_in = 16'h0000;
  logic [19:0] rdata_out, rv;
  logic [12:0] resamp_decimation_factor_out;
  logic [9:0] resamp_interpolation_factor_out;
  logic exp_invert_out, exp_weight_12db_out, bypass_to_selftest_out, use_other_input_out;
  logic coef_bank_high_out, common_exponent_out, force_scale_out, apply_scale_out;
  logic wide_output_out, selftest_busy_out;
  logic [4:0] resamp_scale_out, comb5_scale_out;
  logic [8:0] comb5_decimation_factor_out, coef_filter_decimation_factor_out, tap_count_out;
  logic [7:0] coef_filter_phase_value_out, coefficient_offset_pointer_out;
  logic [1:0] input_source_channel_out, output_format_out;
  logic [3:0] output_scale_out;
  logic [15:0] si, sq, d;
  int num_errors = 0;
  int checks_done = 0;
  logic [7:0] ra [13] = '{8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h9C,
    8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4};
  logic [19:0] rw [13] = '{20'hFFFFF, 20'hFFFFF, 20'hFFFFF, 20'h00000, 20'hFFFFF,
    20'hFFFFF, 20'h00000, 20'h12345, 20'hFFFFF, 20'hFFFFF, 20'hFFFFF, 20'hFFFFF, 20'hFFFFF};
  logic [19:0] rx [13] = '{20'h00FFF, 20'h001FF, 20'h00FFF, 20'h00000, 20'h000FF,
    20'h0001F, 20'h00000, 20'h00000, 20'h000FF, 20'h000FF, 20'h000FF, 20'h000FF, 20'h007FF};
  logic [11:0] cv [5] = '{12'h000, 12'h010, 12'h020, 12'h030, 12'h250};
  logic ca [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};

  // channel 2 takes channel 1 as its other source
  channel_filter_config_bank #(.CHANNEL(2)) u_channel_filter_config_bank (.*);

  always #12.5 clk_in = ~clk_in;

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [19:0] v);
    @(negedge clk_in);
    wr_in = 1'b1;
    addr_in = a;
    wdata_in = v;
    @(negedge clk_in);
    wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk_in);
    rd_in = 1'b1;
    addr_in = a;
    @(negedge clk_in);
    rd_in = 1'b0;
    rv = rdata_out;
  endtask
  // comb data differs from formatted data so the source shows
  task automatic ov(input logic [15:0] i);
    @(negedge clk_in);
    out_valid_in = 1'b1;
    fmt_i_in = i;
    fmt_q_in = ~i;
    comb_i_in = i ^ 16'h5A5A;
    comb_q_in = ~i ^ 16'h5A5A;
    @(negedge clk_in);
    out_valid_in = 1'b0;
  endtask
  task automatic pulse_start();
    @(negedge clk_in);
    filter_start_in = 1'b1;
    @(negedge clk_in);
    filter_start_in = 1'b0;
    @(negedge clk_in);
  endtask
  function automatic logic [15:0] sstep(input logic [15:0] s, input logic [15:0] v);
    return ((s >> 1) ^ (s[0] ? SIG_POLY : 16'h0000)) ^ v;
  endfunction
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge clk_in);
    chk(20'(resamp_decimation_factor_out), 20'h00001);
    chk(20'(tap_count_out), 20'h00001);
    chk(20'(input_source_channel_out), 20'h00002);
    chk(20'(apply_scale_out), 20'h00001);
    nrst_in = 1'b1;
    $display("reset test done");
    for (int k = 0; k < 13; k++) begin
      rd(ra[k]);
      chk(rv, 20'h00000);
      wr(ra[k], rw[k]);
      rd(ra[k]);
      chk(rv, rx[k]);
    end
    $display("register table test done");
    chk(20'(resamp_decimation_factor_out), 20'h01000);
    chk(20'(resamp_interpolation_factor_out), 20'h00200);
    chk(20'(comb5_decimation_factor_out), 20'h00100);
    chk(20'(coef_filter_decimation_factor_out), 20'h00100);
    chk(20'(tap_count_out), 20'h00100);
    chk(20'(comb5_scale_out), 20'h0001F);
    // offset and phase wait for the next filter start
    chk(20'(coefficient_offset_pointer_out), 20'h00000);
    chk(20'(coef_filter_phase_value_out), 20'h00000);
    pulse_start();
    chk(20'(coefficient_offset_pointer_out), 20'h000FF);
    chk(20'(coef_filter_phase_value_out), 20'h000FF);
    $display("boundary and shadow test done");
    wr(A_RESAMP_SCALE, 20'h00AAA);
    @(negedge clk_in);
    chk(20'({exp_invert_out, exp_weight_12db_out}), 20'h00002);
    chk(20'(resamp_scale_out), 20'h00015);
    level_ind_in = 1'b1;
    @(negedge clk_in);
    @(negedge clk_in);
    chk(20'(resamp_scale_out), 20'h0000A);
    wr(A_RESAMP_SCALE, 20'h00400);
    @(negedge clk_in);
    chk(20'({exp_invert_out, exp_weight_12db_out}), 20'h00001);
    $display("scale test done");
    for (int k = 0; k < 5; k++) begin
      wr(A_CF_CTRL, {8'h00, cv[k]});
      @(negedge clk_in);
      chk(20'(apply_scale_out), 20'(ca[k]));
      chk(20'(input_source_channel_out), cv[k][9] ? 20'h00001 : 20'h00002);
    end
    $display("control test done");
    wr(A_OUT_CTRL, 20'h00000);
    // second run takes the comb data through the bypass
    for (int r = 0; r < 2; r++) begin
      wr(A_CF_CTRL, r ? 20'h00400 : 20'h00000);
      wr(A_ST_COUNT, 20'(3 - r));
      si = 16'h0000;
      sq = 16'h0000;
      @(negedge clk_in);
      @(negedge clk_in);
      chk(20'(selftest_busy_out), 20'h00001);
      for (int k = 0; k < 4; k++) begin
        d = 16'(k * 16'h1111 + 16'h00F0);
        ov(d);
        if (k < 3 - r) begin
          si = sstep(si, r ? d ^ 16'h5A5A : d);
          sq = sstep(sq, r ? ~d ^ 16'h5A5A : ~d);
        end
        if (k == 0) begin
          rd(A_ST_COUNT);
          chk(rv, 20'(2 - r));
        end
      end
      for (int w = 0; w < 8 && selftest_busy_out !== 1'b0; w++) @(negedge clk_in);
      if (selftest_busy_out !== 1'b0) begin
        num_errors++;
        $display("Error at %0t: got %h expected %h", $time, selftest_busy_out, 1'b0);
        close_out();
      end
      rd(A_ST_I);
      chk(rv, 20'(si));
      rd(A_ST_Q);
      chk(rv, 20'(sq));
      rd(A_ST_COUNT);
      chk(rv, 20'h00000);
    end
    $display("self test done");
    wr(A_OUT_CTRL, 20'h00220);
    ov(16'hBEEF);
    rd(A_ST_I);
    chk(rv, 20'h0E4B5);
    rd(A_ST_Q);
    chk(rv, 20'h01B4A);
    chk(20'(wide_output_out), 20'h00001);
    wr(A_CF_CTRL, 20'h00000);
    ov(16'h0123);
    rd(A_ST_I);
    chk(rv, 20'h00123);
    $display("mapped output test done");
    close_out();
  end
endmodule
